// *** bench/host_model.sv ***
`timescale 1ns/10ps
module host_model (
    // Clock
    input  wire logic               clk,
    // Register port
    output cmdirq_pkg::reg_req_t    req,
    input  wire logic [7:0]         rdata,
    // Interrupt line
    input  wire logic               pin_out,
    input  wire logic               pin_oe,
    output logic                    pin_level
);
    // Board pull-up holds the line high while undriven
    assign pin_level = pin_oe ? pin_out : 1'b1;

    initial req = '0;

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= v;
        @(posedge clk);
        req.wr    <= 1'b0;
        req.addr  <= ~a;
        req.wdata <= ~v;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd   <= 1'b0;
        req.addr <= ~a;
        @(negedge clk);
        v = rdata;
    endtask
endmodule

// *** bench/test_command_and_irq_enable_regs.sv ***
`timescale 1ns/10ps
module test_command_and_irq_enable_regs;
    logic                    clk;
    logic                    srst;
    logic                    ce;
    logic                    cmd_done;
    logic                    ext_in;
    cmdirq_pkg::req_events_t events;
    cmdirq_pkg::reg_req_t    req;
    logic [7:0]              rdata;
    logic [3:0]              cmd_op;
    logic                    cmd_start;
    logic                    receiver_off;
    logic                    power_down;
    logic                    irq;
    logic                    pin_out;
    logic                    pin_oe;
    logic                    pin_level;
    logic [7:0]              pie_v;
    logic [7:0]              sie_v;
    logic [7:0]              d;
    int                      bad_count;
    int                      num_checks;
    int                      n;

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    command_and_irq_enable_regs #(.SOFT_RESTART_OP(4'hF), .WAKE_CYCLES(4)) dut (
        .clk(clk), .srst(srst), .ce(ce), .req(req), .rdata(rdata),
        .cmd_done(cmd_done), .cmd_op(cmd_op), .cmd_start(cmd_start),
        .events(events), .external_serial_input(ext_in),
        .receiver_off(receiver_off), .power_down(power_down), .irq(irq),
        .irq_pin_out(pin_out), .irq_pin_oe(pin_oe));

    host_model host (.clk(clk), .req(req), .rdata(rdata), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(pin_level));

    function automatic logic [7:0] exp_sie(input logic [7:0] v);
        return v & 8'h94;
    endfunction

    task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", name, e, g);
            bad_count++;
        end
    endtask

    task automatic chk_bit(input string name, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %b seen %b", name, e, g);
            bad_count++;
        end
    endtask

    task automatic chk_reg(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk_byte("rdata", e, v);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Mode 0 pulses an event, 1 ends the command, 2 toggles the external input
    task automatic irq_case(input int mode, input logic [6:0] ev, input logic [5:0] a,
                            input int pos);
        logic [7:0] en;
        logic       e;
        en = 8'($urandom);
        host.wr(a, en);
        if (a == cmdirq_pkg::REG_PIE)
            pie_v = en;
        else
            sie_v = exp_sie(en);
        host.wr(cmdirq_pkg::REG_PST, 8'hFF);
        host.wr(cmdirq_pkg::REG_SST, 8'hFF);
        @(posedge clk);
        if (mode == 0)
            events <= cmdirq_pkg::req_events_t'(ev);
        else if (mode == 1)
            cmd_done <= 1'b1;
        else
            ext_in <= ~ext_in;
        @(posedge clk);
        events   <= '0;
        cmd_done <= 1'b0;
        repeat (7) @(posedge clk);
        @(negedge clk);
        e = (a == cmdirq_pkg::REG_PIE) ? pie_v[pos] : sie_v[pos];
        chk_bit("irq", e, irq);
        chk_bit("pin_level", e ^ pie_v[7], pin_level);
        chk_bit("pin_oe", sie_v[7] | ~(e ^ pie_v[7]), pin_oe);
        host.wr(cmdirq_pkg::REG_PST, 8'hFF);
        host.wr(cmdirq_pkg::REG_SST, 8'hFF);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit("irq", 1'b0, irq);
    endtask

    initial
    begin
        srst       = 1'b1;
        ce         = 1'b1;
        cmd_done   = 1'b0;
        ext_in     = 1'b0;
        events     = '0;
        bad_count  = 0;
        num_checks = 0;
        n          = $urandom(32'h6785);
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit("receiver_off", 1'b1, receiver_off);
        chk_bit("pin_oe", 1'b0, pin_oe);
        chk_bit("pin_level", 1'b1, pin_level);
        chk_reg(cmdirq_pkg::REG_RSVD, 8'h00);
        chk_reg(cmdirq_pkg::REG_CMD, 8'h20);
        chk_reg(cmdirq_pkg::REG_PIE, 8'h80);
        chk_reg(cmdirq_pkg::REG_SIE, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($urandom);
            host.wr(cmdirq_pkg::REG_RSVD, d);
            chk_reg(cmdirq_pkg::REG_RSVD, 8'h00);
            host.wr(cmdirq_pkg::REG_SIE, d);
            chk_reg(cmdirq_pkg::REG_SIE, exp_sie(d));
            host.wr(cmdirq_pkg::REG_PIE, d);
            chk_reg(cmdirq_pkg::REG_PIE, d);
            host.wr(6'h3A, d);
            chk_reg(6'h3A, 8'h00);
        end
        pie_v = d;
        sie_v = exp_sie(d);
        @(posedge clk);
        ce <= 1'b0;
        host.wr(cmdirq_pkg::REG_PIE, ~pie_v);
        ce <= 1'b1;
        chk_reg(cmdirq_pkg::REG_PIE, pie_v);
        host.wr(cmdirq_pkg::REG_CMD, 8'h13);
        @(negedge clk);
        chk_bit("cmd_start", 1'b1, cmd_start);
        chk_byte("cmd_op", 8'h03, {4'h0, cmd_op});
        chk_bit("power_down", 1'b1, power_down);
        chk_bit("receiver_off", 1'b0, receiver_off);
        chk_reg(cmdirq_pkg::REG_CMD, 8'h13);
        host.wr(cmdirq_pkg::REG_CMD, 8'h03);
        chk_reg(cmdirq_pkg::REG_CMD, 8'h13);
        n = 0;
        while (power_down === 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk_bit("power_down", 1'b0, power_down);
        chk_byte("wake_wait", 8'h02, 8'(n));
        chk_reg(cmdirq_pkg::REG_CMD, 8'h03);
        host.wr(cmdirq_pkg::REG_CMD, 8'h1F);
        @(negedge clk);
        chk_bit("power_down", 1'b0, power_down);
        chk_reg(cmdirq_pkg::REG_CMD, 8'h0F);
        host.wr(cmdirq_pkg::REG_CMD, 8'h13);
        @(negedge clk);
        chk_bit("power_down", 1'b0, power_down);
        chk_reg(cmdirq_pkg::REG_CMD, 8'h03);
        @(posedge clk);
        cmd_done <= 1'b1;
        @(posedge clk);
        cmd_done <= 1'b0;
        chk_reg(cmdirq_pkg::REG_CMD, 8'h00);
        host.wr(cmdirq_pkg::REG_CMD, 8'h20);
        @(negedge clk);
        chk_bit("receiver_off", 1'b1, receiver_off);
        for (int r = 0; r < 3; r++)
        begin
            for (int k = 0; k < 6; k++)
                irq_case(0, 7'h40 >> k, cmdirq_pkg::REG_PIE, (k < 2) ? 6 - k : 5 - k);
            irq_case(0, 7'h01, cmdirq_pkg::REG_SIE, 2);
            irq_case(1, 7'h00, cmdirq_pkg::REG_PIE, 4);
            irq_case(2, 7'h00, cmdirq_pkg::REG_SIE, 4);
        end
        host.wr(cmdirq_pkg::REG_CMD, 8'h13);
        @(negedge clk);
        chk_bit("power_down", 1'b1, power_down);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit("power_down", 1'b0, power_down);
        chk_bit("irq", 1'b0, irq);
        chk_bit("pin_oe", 1'b0, pin_oe);
        chk_reg(cmdirq_pkg::REG_CMD, 8'h20);
        chk_reg(cmdirq_pkg::REG_PIE, 8'h80);
        chk_reg(cmdirq_pkg::REG_SIE, 8'h00);
        chk_reg(cmdirq_pkg::REG_SST, 8'h00);
        summarize();
    end
endmodule

// *** hw/cmdirq_pkg.sv ***
// Operation
// - Address 00h reserved, reads zero, reset 00h
// - Command register at 01h, resets to 20h
// - Bit 5 set switches receiver analog off
// - Writing bit 4 high enters sleep
// - Clearing bit 4 wakes; reads one until ready
// - Sleep refused while software restart runs
// - Op field starts command; reads running op
// - Primary enable at 02h, resets 80h, RW
// - Bit 7 inverts combined status on pin
// - Default invert with open drain leaves pin floating
// - Primary bits 6..0 allow seven requests
// - Secondary enable at 03h, resets 00h, reserved bits
// - Secondary bit 7 selects push-pull or open-drain
// - Secondary bits 4, 2 allow input, checksum
package cmdirq_pkg;

    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int OP_W   = 4;

    localparam logic [ADDR_W-1:0] REG_RSVD = 6'h00;
    localparam logic [ADDR_W-1:0] REG_CMD  = 6'h01;
    localparam logic [ADDR_W-1:0] REG_PIE  = 6'h02;
    localparam logic [ADDR_W-1:0] REG_SIE  = 6'h03;
    localparam logic [ADDR_W-1:0] REG_PST  = 6'h04;
    localparam logic [ADDR_W-1:0] REG_SST  = 6'h05;

    localparam logic [DATA_W-1:0] RST_RSVD = 8'h00;
    localparam logic [DATA_W-1:0] RST_CMD  = 8'h20;
    localparam logic [DATA_W-1:0] RST_PIE  = 8'h80;
    localparam logic [DATA_W-1:0] RST_SIE  = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_B   = 8'h00;

    localparam int CMD_RX_OFF = 5;
    localparam int CMD_SLEEP  = 4;
    localparam int PIE_INV    = 7;
    localparam int SIE_DRIVE  = 7;
    localparam int SIE_EXT    = 4;
    localparam int SIE_CRC    = 2;
    localparam int PRI_N      = 7;

    localparam logic [DATA_W-1:0] SIE_WR_MASK  = 8'h94;
    localparam logic [DATA_W-1:0] SIE_EVT_MASK = 8'h14;
    localparam logic [OP_W-1:0]   OP_IDLE      = 4'h0;

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } reg_req_t;

    typedef struct packed {
        logic transmit_done;
        logic receive_done;
        logic fill_high;
        logic fill_low;
        logic fault;
        logic countdown;
        logic checksum_done;
    } req_events_t;

    typedef enum logic [2:0] {
        ST_AWAKE  = 3'b001,
        ST_ASLEEP = 3'b010,
        ST_WAKING = 3'b100
    } sleep_state_t;

endpackage

// *** hw/command_and_irq_enable_regs.sv ***
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module command_and_irq_enable_regs #(
    parameter logic [3:0] SOFT_RESTART_OP = 4'hF,
    parameter int         WAKE_CYCLES     = 16
) (
    // Clock, reset, enable
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic                          ce,
    // Register port
    input  wire cmdirq_pkg::reg_req_t          req,
    output logic [cmdirq_pkg::DATA_W-1:0]      rdata,
    // Command engine
    input  wire logic                          cmd_done,
    output logic [cmdirq_pkg::OP_W-1:0]        cmd_op,
    output logic                               cmd_start,
    // Request sources
    input  wire cmdirq_pkg::req_events_t       events,
    input  wire logic                          external_serial_input,
    // Power control
    output logic                               receiver_off,
    output logic                               power_down,
    // Interrupt
    output logic                               irq,
    output logic                               irq_pin_out,
    output logic                               irq_pin_oe
);

    localparam int CNT_W = $clog2(WAKE_CYCLES + 1);
    localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
    localparam int               EXT_FILL  = 4;

    function automatic logic hit(input logic [cmdirq_pkg::ADDR_W-1:0] a,
                                 input logic [cmdirq_pkg::ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    logic                              rx_off_r;
    logic [cmdirq_pkg::OP_W-1:0]       op_r;
    logic                              start_r;
    cmdirq_pkg::sleep_state_t          state_r;
    cmdirq_pkg::sleep_state_t          state_nxt;
    logic [CNT_W-1:0]                  wake_cnt_r;
    logic [cmdirq_pkg::DATA_W-1:0]     pie_r;
    logic [cmdirq_pkg::DATA_W-1:0]     sie_r;
    logic [cmdirq_pkg::PRI_N-1:0]      pri_flag_r;
    logic [cmdirq_pkg::PRI_N-1:0]      pri_set;
    logic [cmdirq_pkg::DATA_W-1:0]     sec_flag_r;
    logic [cmdirq_pkg::DATA_W-1:0]     sec_set;
    logic [cmdirq_pkg::DATA_W-1:0]     rdata_r;
    logic [cmdirq_pkg::DATA_W-1:0]     rd_nxt;
    logic                              irq_r;
    logic                              pin_out_r;
    logic                              pin_oe_r;
    logic                              ext_s1_r;
    logic                              ext_s2_r;
    logic                              ext_s3_r;
    logic                              ext_stable_r;
    logic [EXT_FILL-1:0]               ext_fill_r;
    logic                              pd_r;
    logic                              ext_edge;
    logic                              cmd_wr;
    logic                              sleep_ok;
    logic                              combined;
    logic                              level;

    assign cmd_wr = req.wr && hit(req.addr, cmdirq_pkg::REG_CMD);

    // Sleep is refused while the restart op runs or is being written
    assign sleep_ok = (op_r != SOFT_RESTART_OP)
                   && (req.wdata[cmdirq_pkg::OP_W-1:0] != SOFT_RESTART_OP);

    // Receiver shutoff bit
    always_ff @(posedge clk)
    begin
        if (srst)
            rx_off_r <= cmdirq_pkg::RST_CMD[cmdirq_pkg::CMD_RX_OFF];
        else if (ce && cmd_wr)
            rx_off_r <= req.wdata[cmdirq_pkg::CMD_RX_OFF];
    end

    // Running operation code
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            op_r    <= cmdirq_pkg::RST_CMD[cmdirq_pkg::OP_W-1:0];
            start_r <= 1'b0;
        end
        else if (ce)
        begin
            start_r <= cmd_wr;
            if (cmd_wr)
                op_r <= req.wdata[cmdirq_pkg::OP_W-1:0];
            else if (cmd_done)
                op_r <= cmdirq_pkg::OP_IDLE;
        end
    end

    // Sleep state machine
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            cmdirq_pkg::ST_AWAKE:
                if (cmd_wr && req.wdata[cmdirq_pkg::CMD_SLEEP] && sleep_ok)
                    state_nxt = cmdirq_pkg::ST_ASLEEP;
            cmdirq_pkg::ST_ASLEEP:
                if (cmd_wr && !req.wdata[cmdirq_pkg::CMD_SLEEP])
                    state_nxt = cmdirq_pkg::ST_WAKING;
            cmdirq_pkg::ST_WAKING:
                if (cmd_wr && req.wdata[cmdirq_pkg::CMD_SLEEP] && sleep_ok)
                    state_nxt = cmdirq_pkg::ST_ASLEEP;
                else if (wake_cnt_r == WAKE_LAST)
                    state_nxt = cmdirq_pkg::ST_AWAKE;
            default:
                state_nxt = cmdirq_pkg::ST_AWAKE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_r <= cmdirq_pkg::ST_AWAKE;
        else if (ce)
            state_r <= state_nxt;
    end

    // Power-down output flop
    always_ff @(posedge clk)
    begin
        if (srst)
            pd_r <= 1'b0;
        else if (ce)
            pd_r <= (state_nxt != cmdirq_pkg::ST_AWAKE);
    end

    // Wake-up timer
    always_ff @(posedge clk)
    begin
        if (srst)
            wake_cnt_r <= CNT_ZERO;
        else if (ce)
        begin
            if (state_r == cmdirq_pkg::ST_WAKING && state_nxt == cmdirq_pkg::ST_WAKING)
                wake_cnt_r <= wake_cnt_r + CNT_W'(1);
            else
                wake_cnt_r <= CNT_ZERO;
        end
    end

    // Enable registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pie_r <= cmdirq_pkg::RST_PIE;
            sie_r <= cmdirq_pkg::RST_SIE;
        end
        else if (ce && req.wr)
        begin
            if (hit(req.addr, cmdirq_pkg::REG_PIE))
                pie_r <= req.wdata;
            if (hit(req.addr, cmdirq_pkg::REG_SIE))
                sie_r <= req.wdata & cmdirq_pkg::SIE_WR_MASK;
        end
    end

    // External input synchroniser and edge detect
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ext_s1_r     <= 1'b0;
            ext_s2_r     <= 1'b0;
            ext_s3_r     <= 1'b0;
            ext_stable_r <= 1'b0;
            ext_fill_r   <= '0;
        end
        else if (ce)
        begin
            ext_s1_r <= external_serial_input;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
            ext_fill_r <= {ext_fill_r[EXT_FILL-2:0], 1'b1};
            if (ext_s2_r == ext_s3_r)
                ext_stable_r <= ext_s3_r;
        end
    end

    // No edge until every stage holds a real pin sample after reset
    assign ext_edge = (&ext_fill_r) && (ext_s2_r == ext_s3_r) && (ext_s3_r != ext_stable_r);

    // Sticky request flags, set wins over clear
    assign pri_set = {events.transmit_done, events.receive_done, cmd_done,
                      events.fill_high, events.fill_low, events.fault,
                      events.countdown};

    always_comb
    begin
        sec_set = cmdirq_pkg::ZERO_B;
        sec_set[cmdirq_pkg::SIE_EXT] = ext_edge;
        sec_set[cmdirq_pkg::SIE_CRC] = events.checksum_done;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pri_flag_r <= '0;
            sec_flag_r <= cmdirq_pkg::ZERO_B;
        end
        else if (ce)
        begin
            if (req.wr && hit(req.addr, cmdirq_pkg::REG_PST))
                pri_flag_r <= (pri_flag_r & ~req.wdata[cmdirq_pkg::PRI_N-1:0]) | pri_set;
            else
                pri_flag_r <= pri_flag_r | pri_set;
            if (req.wr && hit(req.addr, cmdirq_pkg::REG_SST))
                sec_flag_r <= (sec_flag_r & ~req.wdata) | sec_set;
            else
                sec_flag_r <= sec_flag_r | sec_set;
        end
    end

    // Combined status and pin driver
    assign combined = (|(pri_flag_r & pie_r[cmdirq_pkg::PRI_N-1:0]))
                    | (|(sec_flag_r & sie_r & cmdirq_pkg::SIE_EVT_MASK));
    assign level = combined ^ pie_r[cmdirq_pkg::PIE_INV];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_r     <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r  <= 1'b0;
        end
        else if (ce)
        begin
            irq_r <= combined;
            if (sie_r[cmdirq_pkg::SIE_DRIVE])
            begin
                pin_out_r <= level;
                pin_oe_r  <= 1'b1;
            end
            else
            begin
                pin_out_r <= 1'b0;
                pin_oe_r  <= ~level;
            end
        end
    end

    // Read data, one cycle after the strobe
    always_comb
    begin
        rd_nxt = cmdirq_pkg::ZERO_B;
        case (1'b1)
            hit(req.addr, cmdirq_pkg::REG_RSVD):
                rd_nxt = cmdirq_pkg::RST_RSVD;
            hit(req.addr, cmdirq_pkg::REG_CMD):
            begin
                rd_nxt[cmdirq_pkg::CMD_RX_OFF] = rx_off_r;
                rd_nxt[cmdirq_pkg::CMD_SLEEP]  = (state_r != cmdirq_pkg::ST_AWAKE);
                rd_nxt[cmdirq_pkg::OP_W-1:0]   = op_r;
            end
            hit(req.addr, cmdirq_pkg::REG_PIE):
                rd_nxt = pie_r;
            hit(req.addr, cmdirq_pkg::REG_SIE):
                rd_nxt = sie_r;
            hit(req.addr, cmdirq_pkg::REG_PST):
                rd_nxt[cmdirq_pkg::PRI_N-1:0] = pri_flag_r;
            hit(req.addr, cmdirq_pkg::REG_SST):
                rd_nxt = sec_flag_r;
            default:
                rd_nxt = cmdirq_pkg::ZERO_B;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_r <= cmdirq_pkg::ZERO_B;
        else if (ce)
            rdata_r <= req.rd ? rd_nxt : cmdirq_pkg::ZERO_B;
    end

    assign rdata        = rdata_r;
    assign cmd_op       = op_r;
    assign cmd_start    = start_r;
    assign receiver_off = rx_off_r;
    assign power_down   = pd_r;
    assign irq          = irq_r;
    assign irq_pin_out  = pin_out_r;
    assign irq_pin_oe   = pin_oe_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_rsvd_read;
        (ce && req.rd && hit(req.addr, cmdirq_pkg::REG_RSVD)) |=> (rdata == cmdirq_pkg::ZERO_B);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved slot not zero");

    property p_reset_values;
        disable iff (1'b0)
        srst |=> (receiver_off && op_r == cmdirq_pkg::OP_IDLE
                  && pie_r == cmdirq_pkg::RST_PIE && sie_r == cmdirq_pkg::RST_SIE);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");

    property p_rx_off;
        (ce && cmd_wr) |=> (receiver_off == $past(req.wdata[cmdirq_pkg::CMD_RX_OFF]));
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receiver shutoff not taken");

    property p_sleep_enter;
        (ce && cmd_wr && req.wdata[cmdirq_pkg::CMD_SLEEP] && sleep_ok) |=> power_down;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

    property p_wake_done;
        $fell(power_down) |-> ($past(state_r) == cmdirq_pkg::ST_WAKING);
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("woke without wake-up");

    property p_refuse;
        (ce && cmd_wr && state_r == cmdirq_pkg::ST_AWAKE
            && (op_r == SOFT_RESTART_OP
                || req.wdata[cmdirq_pkg::OP_W-1:0] == SOFT_RESTART_OP))
            |=> !power_down;
    endproperty
    a_refuse: assert property (p_refuse) else $error("sleep during restart op");

    property p_op_write;
        (ce && cmd_wr) |=> (cmd_op == $past(req.wdata[cmdirq_pkg::OP_W-1:0])) && cmd_start;
    endproperty
    a_op_write: assert property (p_op_write) else $error("op not taken");

    property p_push_pull;
        (ce && sie_r[cmdirq_pkg::SIE_DRIVE])
            |=> irq_pin_oe
                && (irq_pin_out == ($past(combined) ^ $past(pie_r[cmdirq_pkg::PIE_INV])));
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("pin level wrong");

    property p_float;
        (ce && pie_r[cmdirq_pkg::PIE_INV] && !sie_r[cmdirq_pkg::SIE_DRIVE] && !combined)
            |=> !irq_pin_oe;
    endproperty
    a_float: assert property (p_float) else $error("pin not floating");

    property p_sie_rsvd;
        (ce && req.wr && hit(req.addr, cmdirq_pkg::REG_SIE))
            |=> ((sie_r & ~cmdirq_pkg::SIE_WR_MASK) == cmdirq_pkg::ZERO_B);
    endproperty
    a_sie_rsvd: assert property (p_sie_rsvd) else $error("reserved enable bit set");

    property p_combined;
        (ce && |(pri_flag_r & pie_r[cmdirq_pkg::PRI_N-1:0])) |=> irq;
    endproperty
    a_combined: assert property (p_combined) else $error("enabled flag lost");

    property p_open_drain;
        (ce && !sie_r[cmdirq_pkg::SIE_DRIVE])
            |=> !irq_pin_out
                && (irq_pin_oe != ($past(combined) ^ $past(pie_r[cmdirq_pkg::PIE_INV])));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open-drain pin wrong");

    property p_pie_write;
        (ce && req.wr && hit(req.addr, cmdirq_pkg::REG_PIE))
            |=> (pie_r == $past(req.wdata));
    endproperty
    a_pie_write: assert property (p_pie_write) else $error("primary enable not written");

    property p_ext_flag;
        (ce && ext_edge) |=> sec_flag_r[cmdirq_pkg::SIE_EXT];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("input activity flag lost");

    c_wake_cycle: cover property (state_r == cmdirq_pkg::ST_WAKING ##1 !power_down);
    c_ext_edge:   cover property (ce && ext_edge);
    c_irq_pulled: cover property (irq && irq_pin_oe && !irq_pin_out);
    c_sleep_refused: cover property (cmd_wr && req.wdata[cmdirq_pkg::CMD_SLEEP] && !sleep_ok);

endmodule
